// ---- include/hostport_pkg.sv ----
// package: constants and carriers for the host-side async host port controller
// Summary of operation
// - address bit 2 drives control select
// - read/write line drives direction input
// - chip select doubles as transfer strobe
// - ready drives size acknowledge; wait for it
// - straps: CPU on, 32-bit boot, base default
// - autovector input tied to zero
// - hold request/ack glued to bus arbitration
// - autovector ends only interrupt acknowledge
// - internal block 8 KB, RAM then registers
// - base register valid when bit 0 set
// - acknowledge select field written 11
// - parity bus error enable written zero
// - eight chip selects, line 0 boots
// - negate, relax, parity bits cleared
// - one status register reports all banks
// - port size field written 11
// - cycle length 1111, never zero
package hostport_pkg;

    // software-facing register offsets (controller's own)
    localparam logic [3:0] OFS_CTRL    = 4'h0;
    localparam logic [3:0] OFS_ADDR    = 4'h4;
    localparam logic [3:0] OFS_WDATA   = 4'h8;
    localparam logic [3:0] OFS_RDATA   = 4'hC;
    localparam logic [3:0] OFS_STATUS  = 4'h1;
    localparam logic [3:0] OFS_IRQ     = 4'h2;
    localparam logic [3:0] OFS_CONFIG  = 4'h3;

    // control register fields
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_WRITE_BIT  = 1;
    localparam int CTRL_BE_LSB     = 4;
    localparam int CTRL_CS_LSB     = 8;
    localparam int CTRL_LEVEL_LSB  = 12;

    // host configuration values
    localparam logic [2:0]  CONFIG_STRAP     = 3'h4;
    localparam logic [31:0] MODULE_BASE_REG_DEFAULT     = 32'h0003FF00;
    localparam logic [1:0]  ACK_SELECT_EXT   = 2'h3;
    localparam logic [1:0]  PORT_SIZE_EXT    = 2'h3;
    localparam logic [3:0]  CYCLE_LEN_MAX    = 4'hF;
    localparam logic [12:0] BLOCK_BYTES      = 13'h1000 << 1;
    localparam logic [12:0] HALF_BYTES       = 13'h1000;
    localparam logic [2:0]  NMI_LEVEL        = 3'h7;
    localparam int          NUM_CS           = 8;

    // timing: chip select width and negated gap, in ns
    localparam int CS_LOW_NS   = 75;
    localparam int CS_HIGH_NS  = 35;
    localparam int CLK_NS      = 10;
    localparam int CS_LOW_CYC  = (CS_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int TIMEOUT_CYC = 4095;

    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h00000000;

    // transfer state machine, gray from idle to gap; gap back to idle flips two bits
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_WAIT  = 3'b011,
        ST_HOLD  = 3'b010,
        ST_GAP   = 3'b110
    } xfer_state_type;

    // pins toward the device port
    typedef struct packed {
        logic        ctrl_select_in;
        logic        dir_in;
        logic [NUM_CS-1:0] host_chip_sel_n;
        logic [3:0]  byte_lane_en_n;
        logic [31:0] data_out;
        logic        data_oe;
    } port_out_type;

    // host configuration image applied to the memory controller
    typedef struct packed {
        logic        module_base_reg_valid;
        logic [1:0]  ack_select_field;
        logic        parity_buserr_en;
        logic [1:0]  port_size_field;
        logic [3:0]  cycle_len;
        logic        cs_negate_timing;
        logic        timing_relax_bit;
        logic        parity_check_en;
    } host_cfg_type;

    // a 3-stage input synchroniser settles when stages 2 and 3 agree
    function automatic logic settled(input logic [2:0] s);
        settled = (s[1] == s[2]);
    endfunction

endpackage

// ---- hw/pin_sync.sv ----
// three-flop synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
(
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    // pin and filtered level
    input  wire logic i_pin,
    input  wire logic i_reset_val,
    output logic      o_level
);
    logic [2:0] sync_r;
    logic       level_r;

    // shift chain; stage 0 feeds only stage 1
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            sync_r <= {3{i_reset_val}};   // idle level, so no false edge after reset
        else
            sync_r <= {sync_r[1:0], i_pin};
    end

    // accept a change once stages 2 and 3 agree
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            level_r <= i_reset_val;
        else if (hostport_pkg::settled(sync_r))
            level_r <= sync_r[2];
    end

    assign o_level = level_r;
endmodule

// ---- hw/bus_arb_glue.sv ----
// external arbiter glue between device hold lines and host bus arbitration
`timescale 1ns/1ps
module bus_arb_glue
(
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    // device side (synchronised)
    input  wire logic i_bus_hold_req,
    output logic      o_bus_hold_ack,
    // host arbitration
    output logic      o_bus_request_n,
    input  wire logic i_bus_grant_n,
    output logic      o_bus_grant_ack_n,
    input  wire logic i_host_busy
);
    logic owned_r;

    // take bus when granted and our host side is idle; drop when hold drops
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            owned_r <= 1'b0;
        else if (!i_bus_hold_req)
            owned_r <= 1'b0;
        else if (!i_bus_grant_n && !i_host_busy)
            owned_r <= 1'b1;
    end

    assign o_bus_request_n   = !(i_bus_hold_req && !owned_r);
    assign o_bus_grant_ack_n = !owned_r;
    assign o_bus_hold_ack    = owned_r;

    a_ack_follows_grant: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $rose(owned_r) |-> $past(i_bus_hold_req) && !$past(i_bus_grant_n))
        else $error("bus ack without request and grant");
endmodule

// ---- hw/hostport_ctrl.sv ----
// host-side controller driving the device's asynchronous host port
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
module hostport_ctrl
(
    // clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_rstn,
    // software register port
    input  wire logic [3:0]   i_addr,
    input  wire logic [31:0]  i_wdata,
    input  wire logic         i_wr,
    input  wire logic         i_rd,
    output logic [31:0]       o_rdata,
    // device host port pins
    output logic              o_ctrl_select_in,
    output logic              o_dir_in,
    output logic [7:0]        o_host_chip_sel_n,
    output logic [3:0]        o_byte_lane_en_n,
    output logic [31:0]       o_data_out,
    output logic              o_data_oe,
    input  wire logic [31:0]  i_data_in,
    input  wire logic         i_port_ready_out,
    // interrupt path from device timer pin
    input  wire logic         i_timer_out_pin,
    output logic              o_autovector_in,
    output logic [6:0]        o_host_irq_n,
    input  wire logic         i_irq_ack,
    // arbitration
    input  wire logic         i_bus_hold_req,
    output logic              o_bus_hold_ack,
    output logic              o_bus_request_n,
    input  wire logic         i_bus_grant_n,
    output logic              o_bus_grant_ack_n,
    // straps and configuration image
    output logic [2:0]        o_config_strap,
    output logic              o_host_mode_strap,
    output hostport_pkg::host_cfg_type o_host_cfg
);
    hostport_pkg::xfer_state_type state_r;
    logic [7:0]  cnt_r;
    logic [31:0] ctrl_r;
    logic [31:0] addr_r;
    logic [31:0] wdata_r;
    logic [31:0] rdata_r;
    logic [31:0] module_base_reg_r;
    logic [31:0] rd_out_r;
    logic        done_r;
    logic        timeout_r;
    logic [11:0] wait_r;
    logic        irq_pend_r;
    hostport_pkg::port_out_type pins_r;
    logic        ready_s;
    logic        timer_s;
    logic        hold_s;
    logic        grant_n_s;
    logic        busy;
    logic [2:0]  level;

    assign busy  = (state_r != hostport_pkg::ST_IDLE);
    assign level = ctrl_r[hostport_pkg::CTRL_LEVEL_LSB +: 3];

    // ready is active low on the pin; invert so high means ready
    pin_sync u_ready_sync
    (
        .i_clk_sys   (i_clk_sys),
        .i_rstn      (i_rstn),
        .i_pin       (!i_port_ready_out),
        .i_reset_val (1'b0),
        .o_level     (ready_s)
    );

    pin_sync u_timer_sync
    (
        .i_clk_sys   (i_clk_sys),
        .i_rstn      (i_rstn),
        .i_pin       (i_timer_out_pin),
        .i_reset_val (1'b1),
        .o_level     (timer_s)
    );

    pin_sync u_hold_sync
    (
        .i_clk_sys   (i_clk_sys),
        .i_rstn      (i_rstn),
        .i_pin       (i_bus_hold_req),
        .i_reset_val (1'b0),
        .o_level     (hold_s)
    );

    // bus grant pin idles high
    pin_sync u_grant_sync
    (
        .i_clk_sys   (i_clk_sys),
        .i_rstn      (i_rstn),
        .i_pin       (i_bus_grant_n),
        .i_reset_val (1'b1),
        .o_level     (grant_n_s)
    );

    // arbiter glue for device hold request
    bus_arb_glue u_arb
    (
        .i_clk_sys         (i_clk_sys),
        .i_rstn            (i_rstn),
        .i_bus_hold_req    (hold_s),
        .o_bus_hold_ack    (o_bus_hold_ack),
        .o_bus_request_n   (o_bus_request_n),
        .i_bus_grant_n     (grant_n_s),
        .o_bus_grant_ack_n (o_bus_grant_ack_n),
        .i_host_busy       (busy)
    );

    // software writes
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            ctrl_r  <= hostport_pkg::CTRL_RESET;
            addr_r  <= 32'h00000000;
            wdata_r <= 32'h00000000;
            module_base_reg_r  <= hostport_pkg::MODULE_BASE_REG_DEFAULT;
        end
        else
        begin
            if (i_wr && i_addr == hostport_pkg::OFS_CTRL && !busy)
                ctrl_r <= i_wdata;
            else if (state_r == hostport_pkg::ST_SETUP)
                ctrl_r[hostport_pkg::CTRL_START_BIT] <= 1'b0;
            if (i_wr && i_addr == hostport_pkg::OFS_ADDR)
                addr_r <= i_wdata;
            if (i_wr && i_addr == hostport_pkg::OFS_WDATA)
                wdata_r <= i_wdata;
            if (i_wr && i_addr == hostport_pkg::OFS_CONFIG)
                module_base_reg_r <= {i_wdata[31:13], 12'h000, i_wdata[0]};   // 8 KB aligned
        end
    end

    // transfer sequencer
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            state_r <= hostport_pkg::ST_IDLE;
            cnt_r   <= 8'h00;
            wait_r  <= 12'h000;
        end
        else
        begin
            unique case (state_r)
                hostport_pkg::ST_IDLE:
                    if (ctrl_r[hostport_pkg::CTRL_START_BIT] && !o_bus_hold_ack)
                    begin
                        state_r <= hostport_pkg::ST_SETUP;
                        cnt_r   <= 8'h00;
                    end
                hostport_pkg::ST_SETUP:
                begin
                    state_r <= hostport_pkg::ST_WAIT;
                    cnt_r   <= 8'h00;
                    wait_r  <= 12'h000;
                end
                hostport_pkg::ST_WAIT:
                begin
                    if (cnt_r != 8'hFF)
                        cnt_r <= cnt_r + 8'h01;
                    wait_r <= wait_r + 12'h001;
                    // hold chip select until ready and min width met, or until wait_r reaches the timeout count
                    if ((ready_s && cnt_r >= 8'(hostport_pkg::CS_LOW_CYC - 1))
                        || wait_r == 12'(hostport_pkg::TIMEOUT_CYC))
                    begin
                        state_r <= hostport_pkg::ST_HOLD;
                    end
                end
                hostport_pkg::ST_HOLD:
                begin
                    state_r <= hostport_pkg::ST_GAP;
                    cnt_r   <= 8'h00;
                end
                hostport_pkg::ST_GAP:
                begin
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r >= 8'(hostport_pkg::CS_HIGH_CYC - 1) && !ready_s)
                        state_r <= hostport_pkg::ST_IDLE;
                end
                default:
                    state_r <= hostport_pkg::ST_IDLE;
            endcase
        end
    end

    // pin drive: address bit 2, direction, chip select, byte enables
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            pins_r <= '{ctrl_select_in: 1'b0, dir_in: 1'b1, host_chip_sel_n: 8'hFF,
                        byte_lane_en_n: 4'hF, data_out: 32'h00000000, data_oe: 1'b0};
        end
        else if (state_r == hostport_pkg::ST_IDLE && ctrl_r[hostport_pkg::CTRL_START_BIT]
                 && !o_bus_hold_ack)
        begin
            pins_r.ctrl_select_in <= addr_r[2];
            pins_r.dir_in         <= !ctrl_r[hostport_pkg::CTRL_WRITE_BIT];
            pins_r.byte_lane_en_n <= ~ctrl_r[hostport_pkg::CTRL_BE_LSB +: 4];
            pins_r.data_out       <= wdata_r;
            pins_r.data_oe        <= ctrl_r[hostport_pkg::CTRL_WRITE_BIT];
        end
        else if (state_r == hostport_pkg::ST_SETUP)
        begin
            // one bank's chip select is the strobe
            pins_r.host_chip_sel_n <= ~(8'h01 << ctrl_r[hostport_pkg::CTRL_CS_LSB +: 3]);
        end
        else if (state_r == hostport_pkg::ST_HOLD)
        begin
            pins_r.host_chip_sel_n <= 8'hFF;
        end
        else if (state_r == hostport_pkg::ST_GAP)
        begin
            pins_r.data_oe        <= 1'b0;
            pins_r.byte_lane_en_n <= 4'hF;
            pins_r.dir_in         <= 1'b1;
        end
    end

    // capture read data and completion flags
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            rdata_r   <= 32'h00000000;
            done_r    <= 1'b0;
            timeout_r <= 1'b0;
        end
        else
        begin
            if (state_r == hostport_pkg::ST_WAIT && ready_s && pins_r.dir_in)
                rdata_r <= i_data_in;
            if (state_r == hostport_pkg::ST_HOLD)
            begin
                done_r    <= 1'b1;
                timeout_r <= !ready_s;
            end
            else if (i_wr && i_addr == hostport_pkg::OFS_STATUS && i_wdata[0])
                done_r <= 1'b0;
        end
    end

    // interrupt: timer pin low asserts chosen level, level 7 held to ack
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            irq_pend_r <= 1'b0;
        else if (!timer_s)
            irq_pend_r <= 1'b1;
        else if (level != hostport_pkg::NMI_LEVEL || i_irq_ack)
            irq_pend_r <= 1'b0;
    end

    always_comb
    begin
        o_host_irq_n = 7'h7F;
        if (irq_pend_r && level != 3'h0)
            o_host_irq_n[level - 3'h1] = 1'b0;
    end

    // read port, data one cycle after strobe
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            rd_out_r <= 32'h00000000;
        else if (i_rd)
        begin
            unique case (i_addr)
                hostport_pkg::OFS_CTRL:   rd_out_r <= ctrl_r;
                hostport_pkg::OFS_ADDR:   rd_out_r <= addr_r;
                hostport_pkg::OFS_WDATA:  rd_out_r <= wdata_r;
                hostport_pkg::OFS_RDATA:  rd_out_r <= rdata_r;
                hostport_pkg::OFS_STATUS: rd_out_r <= {27'h0, irq_pend_r, hold_s, timeout_r, busy, done_r};
                hostport_pkg::OFS_CONFIG: rd_out_r <= module_base_reg_r;
                default:                  rd_out_r <= 32'h00000000;
            endcase
        end
        else
            rd_out_r <= 32'h00000000;
    end

    assign o_rdata           = rd_out_r;
    assign o_ctrl_select_in  = pins_r.ctrl_select_in;
    assign o_dir_in          = pins_r.dir_in;
    assign o_host_chip_sel_n = pins_r.host_chip_sel_n;
    assign o_byte_lane_en_n  = pins_r.byte_lane_en_n;
    assign o_data_out        = pins_r.data_out;
    assign o_data_oe         = pins_r.data_oe;
    assign o_autovector_in   = 1'b0;
    assign o_config_strap    = hostport_pkg::CONFIG_STRAP;
    assign o_host_mode_strap = 1'b0;

    // memory controller image for the device bank
    assign o_host_cfg = '{module_base_reg_valid: module_base_reg_r[0],
                          ack_select_field: hostport_pkg::ACK_SELECT_EXT,
                          parity_buserr_en: 1'b0,
                          port_size_field: hostport_pkg::PORT_SIZE_EXT,
                          cycle_len: hostport_pkg::CYCLE_LEN_MAX,
                          cs_negate_timing: 1'b0,
                          timing_relax_bit: 1'b0,
                          parity_check_en: 1'b0};

    // checks
    a_cs_until_ready: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == hostport_pkg::ST_WAIT && !ready_s && wait_r != 12'(hostport_pkg::TIMEOUT_CYC))
        |=> state_r == hostport_pkg::ST_WAIT)
        else $error("chip select dropped before ready");
    a_cs_min_width: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $fell(o_host_chip_sel_n != 8'hFF) |-> $past(o_host_chip_sel_n != 8'hFF, 8))
        else $error("chip select low too short");
    a_one_cs_active: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $onehot0(~o_host_chip_sel_n))
        else $error("more than one chip select");
    a_sel_stable_cs: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (o_host_chip_sel_n != 8'hFF && $past(o_host_chip_sel_n != 8'hFF))
        |-> $stable(o_ctrl_select_in) && $stable(o_dir_in))
        else $error("select changed during strobe");
    a_dir_matches_ctrl: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        state_r == hostport_pkg::ST_WAIT |-> o_dir_in == !o_data_oe)
        else $error("direction and data drive disagree");
    a_nmi_held: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (irq_pend_r && level == hostport_pkg::NMI_LEVEL && !i_irq_ack) |=> irq_pend_r)
        else $error("level 7 request dropped before ack");
    a_irq_on_timer: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !timer_s |=> irq_pend_r)
        else $error("timer pin did not raise request");
    a_no_xfer_on_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_bus_hold_ack |-> o_host_chip_sel_n == 8'hFF || state_r != hostport_pkg::ST_SETUP)
        else $error("transfer started while device holds bus");
    c_write: cover property (@(posedge i_clk_sys) state_r == hostport_pkg::ST_HOLD && o_data_oe);
    c_read: cover property (@(posedge i_clk_sys) state_r == hostport_pkg::ST_HOLD && !o_data_oe);
    c_nmi: cover property (@(posedge i_clk_sys) irq_pend_r && level == hostport_pkg::NMI_LEVEL);
    c_hold: cover property (@(posedge i_clk_sys) o_bus_hold_ack);
endmodule

// ---- verification/hostport_dev_model.sv ----
// device host port model: async slave answering chip-select strobes
`timescale 1ns/1ps
module hostport_dev_model
(
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    // pins from the controller
    input  wire logic [7:0]  i_cs_n,
    input  wire logic        i_sel,
    input  wire logic        i_dir,
    input  wire logic [3:0]  i_be_n,
    input  wire logic [31:0] i_dout,
    input  wire logic        i_doe,
    input  wire logic [7:0]  i_delay,
    // answers to the controller
    output logic [31:0]      o_din,
    output logic             o_ready_n
);
    logic [31:0] word_r [2];
    logic [31:0] last_r;
    logic [7:0]  wait_r;
    logic        on;
    // any chip-select line low is the strobe
    assign on = (i_cs_n != 8'hFF);
    // ready after the set delay, dropped with select; FF never answers
    assign o_ready_n = !(on && i_delay != 8'hFF && wait_r >= i_delay);
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn || !on)
            wait_r <= 8'h00;
        else if (wait_r != 8'hFF)
            wait_r <= wait_r + 8'h01;
    end
    // wire level: controller, model on reads, else a toggling pattern
    assign o_din = i_doe ? i_dout : (on && i_dir) ? word_r[i_sel] : ~last_r;
    // two words chosen by the control select, written lane by lane
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            last_r <= 32'h0;
            word_r <= '{32'h0, 32'h0};
        end
        else
        begin
            last_r <= o_din;
            if (on && !i_dir && i_doe)
                for (int b = 0; b < 4; b++)
                    if (!i_be_n[b])
                        word_r[i_sel][8*b +: 8] <= i_dout[8*b +: 8];
        end
    end
endmodule

// ---- verification/hostport_ctrl_test.sv ----
// self-checking bench for the host port controller
`timescale 1ns/1ps
module hostport_ctrl_test;
    logic        clk_sys = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, timer_pin = 1'b1, irq_ack = 1'b0;
    logic        hold_req = 1'b0, grant_n = 1'b1, sel, dir, doe, ready_n, autovector_in, hack, breq_n, gack_n, hmode;
    logic [3:0]  addr = 4'h0, be_n;
    logic [31:0] wdata = 32'h0, rdata, dout, din;
    logic [7:0]  cs_n, dly = 8'h00;
    logic [6:0]  irq_n;
    logic [2:0]  strap;
    logic [12:0] cfg;
    int          mismatches = 0, check_count = 0;

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    hostport_ctrl u_dut (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_ctrl_select_in(sel), .o_dir_in(dir), .o_host_chip_sel_n(cs_n),
        .o_byte_lane_en_n(be_n), .o_data_out(dout), .o_data_oe(doe), .i_data_in(din),
        .i_port_ready_out(ready_n), .i_timer_out_pin(timer_pin), .o_autovector_in(autovector_in), .o_host_irq_n(irq_n),
        .i_irq_ack(irq_ack), .i_bus_hold_req(hold_req), .o_bus_hold_ack(hack), .o_bus_request_n(breq_n),
        .i_bus_grant_n(grant_n), .o_bus_grant_ack_n(gack_n), .o_config_strap(strap),
        .o_host_mode_strap(hmode), .o_host_cfg(cfg));
    hostport_dev_model u_dev (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_cs_n(cs_n), .i_sel(sel), .i_dir(dir),
        .i_be_n(be_n), .i_dout(dout), .i_doe(doe), .i_delay(dly), .o_din(din), .o_ready_n(ready_n));

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %08h seen %08h", what, exp, got);
            mismatches++;
        end
    endtask

    // a bounded wait ran out
    task automatic lost(input string what);
        $display("MISMATCH %s expected event seen none", what);
        mismatches++;
        stop_test();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // one-cycle register write and read, data the cycle after
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // poll a status bit under a bound
    task automatic poll(input int b, input int lim);
        logic [31:0] s;
        s = 32'h0;
        for (int n = 0; n < lim && s[b] !== 1'b1; n++)
            rd_reg(hostport_pkg::OFS_STATUS, s);
        if (s[b] !== 1'b1)
            lost("status bit");
    endtask

    // one transfer; blk means the device owns the bus when it starts
    task automatic xfer(input logic w, blk, input logic [3:0] be, input logic [2:0] c, input logic [7:0] t,
                        input logic [31:0] a, d, exp);
        logic [31:0] got;
        int          n;
        int          hi;
        dly <= t;
        wr_reg(hostport_pkg::OFS_ADDR, a);
        wr_reg(hostport_pkg::OFS_WDATA, d);
        wr_reg(hostport_pkg::OFS_CTRL, {21'h0, c, be, 2'h0, w, 1'b1});
        if (blk)
        begin
            tick(20);
            chk("strobe held off", 32'hFF, 32'(cs_n));
            @(posedge clk_sys);
            hold_req <= 1'b0;
            grant_n <= 1'b1;
            #1;
        end
        for (n = 0; n < 100 && cs_n === 8'hFF; n++)
            tick(1);
        if (n == 100)
            lost("chip select");
        chk("strobe line", {24'h0, ~(8'h01 << c)}, 32'(cs_n));
        chk("select dir lanes", {25'h0, a[2], ~w, ~be, w}, {25'h0, sel, dir, be_n, doe});
        for (n = 0; n < 300 && cs_n !== 8'hFF; n++)
            tick(1);
        hi = (t > 8'h04) ? t + 8 : 12;
        chk("strobe width", 32'h1, 32'(n >= 8 && n >= t + 3 && n <= hi));
        poll(0, 50);
        if (!w)
        begin
            rd_reg(hostport_pkg::OFS_RDATA, got);
            chk("read word", exp, got);
        end
        wr_reg(hostport_pkg::OFS_STATUS, 32'h1);
    endtask

    // main sequence
    initial
    begin
        logic [31:0] v;
        logic [2:0]  lvl;
        logic [6:0]  low;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        tick(1);
        chk("idle pins", {8'h0, 8'hFF, 1'b1, 4'hF, 1'b0, 7'h7F, 3'h6},
            {8'h0, cs_n, dir, be_n, doe, irq_n, breq_n, gack_n, hack});
        chk("straps", {27'h0, 3'h4, 2'h0}, {27'h0, strap, hmode, autovector_in});
        chk("host config", 32'h0DF8, 32'(cfg));
        rd_reg(hostport_pkg::OFS_CONFIG, v);
        chk("base reset", 32'h0003FF00, v);
        wr_reg(hostport_pkg::OFS_CONFIG, 32'h0003FFFF);
        rd_reg(hostport_pkg::OFS_CONFIG, v);
        chk("base aligned", 32'h0003E001, v);
        chk("base valid", 32'h1DF8, 32'(cfg));
        wr_reg(4'h5, 32'hFFFFFFFF);
        rd_reg(4'h5, v);
        chk("unmapped", 32'h0, v);
        rd_reg(hostport_pkg::OFS_IRQ, v);
        chk("unused offset", 32'h0, v);
        // writes with lane masks, then reads through both selects
        xfer(1'b1, 1'b0, 4'hF, 3'h0, 8'h00, 32'h4, 32'h11223344, 32'h0);
        xfer(1'b1, 1'b0, 4'h3, 3'h7, 8'h14, 32'h4, 32'hAABBCCDD, 32'h0);
        xfer(1'b1, 1'b0, 4'hF, 3'h3, 8'h05, 32'h0, 32'h55667788, 32'h0);
        xfer(1'b0, 1'b0, 4'hF, 3'h5, 8'h0A, 32'h4, 32'h0, 32'h1122CCDD);
        xfer(1'b0, 1'b0, 4'hF, 3'h1, 8'h00, 32'h0, 32'h0, 32'h55667788);
        // device takes the bus, a start waits for its release
        @(posedge clk_sys);
        hold_req <= 1'b1;
        tick(8);
        chk("bus request", 32'h2, {29'h0, breq_n, gack_n, hack});
        @(posedge clk_sys);
        grant_n <= 1'b0;
        tick(8);
        chk("bus owned", 32'h5, {29'h0, breq_n, gack_n, hack});
        xfer(1'b1, 1'b1, 4'hC, 3'h2, 8'h03, 32'h0, 32'h99000000, 32'h0);
        chk("bus released", 32'h6, {29'h0, breq_n, gack_n, hack});
        // levels 3, 7 and 0 (off)
        for (int i = 0; i < 3; i++)
        begin
            lvl = (i == 0) ? 3'h3 : (i == 1) ? 3'h7 : 3'h0;
            low = (lvl == 3'h0) ? 7'h7F : ~(7'h01 << (lvl - 3'h1));
            wr_reg(hostport_pkg::OFS_CTRL, {17'h0, lvl, 12'h0});
            @(posedge clk_sys);
            timer_pin <= 1'b0;
            tick(10);
            chk("irq raised", 32'(low), 32'(irq_n));
            @(posedge clk_sys);
            timer_pin <= 1'b1;
            tick(10);
            chk("irq after pin", (lvl == 3'h7) ? 32'(low) : 32'h7F, 32'(irq_n));
            @(posedge clk_sys);
            irq_ack <= 1'b1;
            @(posedge clk_sys);
            irq_ack <= 1'b0;
            tick(10);
            chk("irq after ack", 32'h7F, 32'(irq_n));
        end
        // device never answers: the strobe gives up
        dly <= 8'hFF;
        wr_reg(hostport_pkg::OFS_CTRL, 32'h3);
        poll(2, 2500);
        chk("strobe after timeout", 32'hFF, 32'(cs_n));
        stop_test();
    end
endmodule
